// >>> core/fcr_addr_gen.sv
// read address generator with aligned wrap windows
// assumes start and next come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fcr_addr_gen
    import fcr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    fcr_rd_if.gen rd
);
    typedef struct packed {
        logic [23:0] addr;
    } fcr_ag_state_t;

    fcr_ag_state_t s;
    fcr_ag_state_t next_s;
    logic [23:0] mask;
    logic [23:0] inc;

    // window mask from the wrap code
    always_comb begin
        unique case (rd.wrap)
            WRAP_16: mask = MASK_16;
            WRAP_32: mask = MASK_32;
            WRAP_64: mask = MASK_64;
            WRAP_SEQ: mask = '1;
        endcase
        inc = rd.addr + 24'h000001;
        next_s = s;
        if (rd.start) begin
            next_s.addr = rd.start_addr;
        end else if (rd.next) begin
            next_s.addr = (rd.addr & ~mask) | (inc & mask);
        end
    end

    // address register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd.addr = s.addr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_wrap_window_kept: assert property (
        rd.next && !rd.start && rd.wrap != WRAP_SEQ
            |=> (rd.addr & ~$past(mask)) == ($past(rd.addr) & ~$past(mask)))
        else $error("wrapped read left its aligned window");
    a_wrap_returns_start: assert property (
        rd.next && !rd.start && rd.wrap == WRAP_16 && rd.addr[3:0] == 4'hf
            |=> rd.addr[3:0] == 4'h0 && rd.addr[23:4] == $past(rd.addr[23:4]))
        else $error("16-byte wrap did not return to window start");
    a_seq_increments: assert property (
        rd.next && !rd.start && rd.wrap == WRAP_SEQ |=> rd.addr == $past(rd.addr) + 24'h000001)
        else $error("sequential read did not increment");
    c_wrap_64: cover property (rd.next && rd.wrap == WRAP_64 && rd.addr[5:0] == 6'h3f);
endmodule
`default_nettype wire

// >>> core/fcr_core.sv
// configuration register logic of a serial flash: serial command engine, nonvolatile
// and volatile configuration registers, working configuration and wrap address control
// assumes serial pins are asynchronous to clk and the serial clock is far below clk/4
//
// How it works
// - nonvolatile bits 15:12 set dummy clocks after fast reads; 0000 equals 1111
// - dummy codes zero and all ones both give the default count for 108 MHz
// - power-on execute_in_place mode from bits 11:9; 111 disables except in forced variants, 101/110 reserved
// - nonvolatile bit 4 enables the hold/reset pin function, default one
// - nonvolatile bit 3 low enables quad protocol, else extended
// - nonvolatile bit 2 low enables dual protocol, else extended
// - both protocol bits low give quad; cleared bits act only after power-on
// - nonvolatile register delivered as all ones and sets the power-on configuration
// - host reads and writes nonvolatile register with dedicated commands; device executes
// - volatile bits 7:4 set dummy clocks; 0000 equals 1111, the default
// - volatile bit 3 low enables execute_in_place; forced variants ignore it
// - volatile bits 1:0 select wrap; 11 reads sequentially through the array
// - wrap codes 00, 01, 10 confine output to aligned 16, 32, 64 bytes
// - volatile writes act when the write completes; register is readable
// - boot loads working configuration from nonvolatile; volatile writes copy into it
// - write in progress shows busy while a nonvolatile write executes
`timescale 1ns/1ps
`default_nettype none
module fcr_core
    import fcr_pkg::*;
#(
    parameter bit EXEC_FORCED = 1'b0,
    parameter int NV_WRITE_LEN = NV_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic factory_erase,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic rd_start,
    input wire logic [23:0] rd_start_addr,
    input wire logic rd_next,
    output logic [23:0] rd_addr,
    output logic [3:0] dummy_cycles,
    output logic execute_in_place,
    output logic [2:0] execute_in_place_mode,
    output logic hold_reset_enable,
    output logic quad_mode,
    output logic dual_mode,
    output logic [1:0] wrap_mode,
    output logic write_in_progress
);
    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic mosi_s1;
        logic mosi_s2;
        fcr_phase_t phase;
        logic [7:0] shift;
        logic [2:0] bitcnt;
        logic [7:0] cmd;
        logic [1:0] bytecnt;
        logic [15:0] din;
        logic [15:0] dout;
        logic miso;
        logic miso_oe_n;
        logic [15:0] nv_cfg;
        logic [7:0] vol_cfg;
        logic [3:0] dummy;
        logic exec_en;
        logic [2:0] exec_mode;
        logic hold_en;
        logic quad;
        logic dual;
        logic [1:0] wrap;
        logic [15:0] busy;
    } fcr_state_t;

    fcr_state_t s;
    fcr_state_t next_s;
    logic [7:0] byte_in;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic commit_nv;
    logic commit_vol;

    fcr_rd_if rd_bus ();

    // dummy code to clock count; both end codes mean the default
    function automatic logic [3:0] fcr_dummy_eff(input logic [3:0] code);
        if (code == DUMMY_CODE_ZERO || code == DUMMY_CODE_ONES) begin
            return DUMMY_DEFAULT;
        end
        return code;
    endfunction

    // edges seen on the second and third synchroniser stages
    assign byte_in = {s.shift[6:0], s.mosi_s2};
    assign sck_rise = s.sck_s2 & ~s.sck_s3;
    assign sck_fall = ~s.sck_s2 & s.sck_s3;
    assign cs_rise = s.cs_s2 & ~s.cs_s3;
    assign commit_nv = cs_rise && s.phase == FCR_DIN && s.cmd == CMD_WR_NV && s.bytecnt == 2'h2;
    assign commit_vol = cs_rise && s.phase == FCR_DIN && s.cmd == CMD_WR_VOL && s.bytecnt == 2'h1;

    // next state of the whole block
    always_comb begin
        next_s = s;
        next_s.sck_s1 = spi_clk;
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_s3 = s.sck_s2;
        next_s.cs_s1 = spi_cs_n;
        next_s.cs_s2 = s.cs_s1;
        next_s.cs_s3 = s.cs_s2;
        next_s.mosi_s1 = spi_mosi;
        next_s.mosi_s2 = s.mosi_s1;
        if (s.busy != 16'h0000) begin
            next_s.busy = s.busy - 16'h0001;
        end
        if (s.phase == FCR_BOOT) begin
            // working configuration taken from the nonvolatile register
            next_s.dummy = fcr_dummy_eff(s.nv_cfg[NV_DUMMY_HI:NV_DUMMY_LO]);
            next_s.exec_mode = s.nv_cfg[NV_EXEC_HI:NV_EXEC_LO];
            next_s.exec_en = EXEC_FORCED
                | (s.nv_cfg[NV_EXEC_HI:NV_EXEC_LO] != EXEC_MODE_OFF);
            next_s.hold_en = s.nv_cfg[NV_HOLD_BIT];
            next_s.quad = ~s.nv_cfg[NV_QUAD_BIT];
            next_s.dual = s.nv_cfg[NV_QUAD_BIT] & ~s.nv_cfg[NV_DUAL_BIT];
            next_s.vol_cfg = {s.nv_cfg[NV_DUMMY_HI:NV_DUMMY_LO],
                              s.nv_cfg[NV_EXEC_HI:NV_EXEC_LO] == EXEC_MODE_OFF, 1'b0, WRAP_SEQ};
            next_s.wrap = WRAP_SEQ;
            next_s.phase = FCR_IDLE;
        end else if (s.cs_s2) begin
            // deselected: complete a write, then wait for the next command
            if (commit_nv) begin
                next_s.nv_cfg = s.din; // protocol fields wait for next boot
                next_s.busy = 16'(NV_WRITE_LEN);
            end
            if (commit_vol) begin
                next_s.vol_cfg = {s.din[VC_DUMMY_HI:VC_EXEC_BIT], 1'b0, s.din[VC_WRAP_HI:0]};
                next_s.dummy = fcr_dummy_eff(s.din[VC_DUMMY_HI:VC_DUMMY_LO]);
                next_s.exec_en = EXEC_FORCED | ~s.din[VC_EXEC_BIT];
                next_s.wrap = s.din[VC_WRAP_HI:0];
            end
            next_s.phase = FCR_IDLE;
            next_s.bitcnt = 3'h0;
            next_s.bytecnt = 2'h0;
            next_s.miso_oe_n = 1'b1;
        end else begin
            if (sck_rise) begin
                next_s.shift = byte_in;
                next_s.bitcnt = s.bitcnt + 3'h1;
                if (s.bitcnt == 3'h7) begin
                    unique case (s.phase)
                        FCR_IDLE: begin
                            next_s.cmd = byte_in;
                            if (byte_in == CMD_RD_NV) begin
                                next_s.dout = {s.nv_cfg[7:0], s.nv_cfg[15:8]};
                                next_s.phase = FCR_DOUT;
                            end else if (byte_in == CMD_RD_VOL) begin
                                next_s.dout = {s.vol_cfg, s.vol_cfg};
                                next_s.phase = FCR_DOUT;
                            end else if ((byte_in == CMD_WR_NV || byte_in == CMD_WR_VOL)
                                         && s.busy == 16'h0000) begin
                                next_s.phase = FCR_DIN;
                            end else begin
                                next_s.phase = FCR_SKIP;
                            end
                        end
                        FCR_DIN: begin
                            if (s.bytecnt == 2'h0) begin
                                next_s.din[7:0] = byte_in;
                            end else if (s.bytecnt == 2'h1) begin
                                next_s.din[15:8] = byte_in;
                            end
                            if (s.bytecnt != 2'h3) begin
                                next_s.bytecnt = s.bytecnt + 2'h1;
                            end
                        end
                        FCR_BOOT, FCR_DOUT, FCR_SKIP: begin
                        end
                    endcase
                end
            end
            // shift out on falling serial clock, repeating the register
            if (sck_fall && s.phase == FCR_DOUT) begin
                next_s.miso = s.dout[15];
                next_s.dout = {s.dout[14:0], s.dout[15]};
                next_s.miso_oe_n = 1'b0;
            end
        end
    end

    // state register; the nonvolatile store survives reset unless erased
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
            s.phase <= FCR_BOOT;
            s.sck_s1 <= 1'b0;
            s.cs_s1 <= 1'b1;
            s.cs_s2 <= 1'b1;
            s.cs_s3 <= 1'b1;
            s.miso_oe_n <= 1'b1;
            s.nv_cfg <= factory_erase ? NV_DELIVERED : s.nv_cfg;
        end else begin
            s <= next_s;
        end
    end

    // read address path through the wrap generator
    assign rd_bus.start = rd_start;
    assign rd_bus.start_addr = rd_start_addr;
    assign rd_bus.next = rd_next;
    assign rd_bus.wrap = s.wrap;
    assign rd_addr = rd_bus.addr;

    fcr_addr_gen u_addr_gen (
        .clk(clk),
        .reset_n(reset_n),
        .rd(rd_bus)
    );

    // outputs straight from state
    assign spi_miso = s.miso;
    assign spi_miso_oe_n = s.miso_oe_n;
    assign dummy_cycles = s.dummy;
    assign execute_in_place = s.exec_en;
    assign execute_in_place_mode = s.exec_mode;
    assign hold_reset_enable = s.hold_en;
    assign quad_mode = s.quad;
    assign dual_mode = s.dual;
    assign wrap_mode = s.wrap;
    assign write_in_progress = s.busy != 16'h0000;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_dummy_code_folded: assert property (
        s.phase != FCR_BOOT |-> dummy_cycles != DUMMY_CODE_ZERO && dummy_cycles != DUMMY_CODE_ONES)
        else $error("dummy count shows an unfolded end code");
    a_boot_loads_cfg: assert property (
        s.phase == FCR_BOOT |=> quad_mode == ~$past(s.nv_cfg[3])
            && hold_reset_enable == $past(s.nv_cfg[4])
            && execute_in_place_mode == $past(s.nv_cfg[11:9]) && wrap_mode == WRAP_SEQ)
        else $error("boot did not load the working configuration");
    a_protocol_fixed_after: assert property (
        s.phase != FCR_BOOT |=> $stable(quad_mode) && $stable(dual_mode) && $stable(hold_reset_enable))
        else $error("protocol changed outside boot");
    a_quad_over_dual: assert property (
        !(quad_mode && dual_mode))
        else $error("quad and dual both active");
    a_vol_write_acts: assert property (
        commit_vol |=> wrap_mode == $past(s.din[1:0]) && s.vol_cfg[7:4] == $past(s.din[7:4]))
        else $error("volatile write did not take effect");
    a_exec_forced_on: assert property (
        EXEC_FORCED && s.phase != FCR_BOOT |-> execute_in_place)
        else $error("forced variant left execute_in_place off");
    a_nv_busy_span: assert property (
        commit_nv |=> write_in_progress[*8] ##[1:300] !write_in_progress)
        else $error("nonvolatile write busy window wrong");
    a_busy_refuses_write: assert property (
        write_in_progress && s.phase == FCR_IDLE && !s.cs_s2 && sck_rise && s.bitcnt == 3'h7
            && byte_in == CMD_WR_NV |=> s.phase == FCR_SKIP)
        else $error("write accepted while busy");
    a_miso_only_reading: assert property (
        !spi_miso_oe_n |-> $past(s.phase) == FCR_DOUT)
        else $error("output driven outside a register read");
    c_nv_write: cover property (commit_nv);
    c_vol_write: cover property (commit_vol);
    c_nv_read: cover property (s.phase == FCR_DOUT && s.cmd == CMD_RD_NV && sck_fall);
    c_quad_boot: cover property (s.phase == FCR_BOOT ##1 quad_mode);
endmodule
`default_nettype wire

// >>> core/fcr_pkg.sv
// constants, field positions and command codes of the flash configuration registers
// assumes one 200 MHz core clock; serial pins arrive asynchronously
package fcr_pkg;
    // delivered (erased) state of the nonvolatile register
    localparam logic [15:0] NV_DELIVERED = 16'hffff;
    // nonvolatile field positions
    localparam int NV_DUMMY_HI = 15;
    localparam int NV_DUMMY_LO = 12;
    localparam int NV_EXEC_HI = 11;
    localparam int NV_EXEC_LO = 9;
    localparam int NV_HOLD_BIT = 4;
    localparam int NV_QUAD_BIT = 3;
    localparam int NV_DUAL_BIT = 2;
    // volatile field positions
    localparam int VC_DUMMY_HI = 7;
    localparam int VC_DUMMY_LO = 4;
    localparam int VC_EXEC_BIT = 3;
    localparam int VC_WRAP_HI = 1;
    // dummy codes; both ends of the range pick the default count
    localparam logic [3:0] DUMMY_CODE_ZERO = 4'h0;
    localparam logic [3:0] DUMMY_CODE_ONES = 4'hf;
    localparam logic [3:0] DUMMY_DEFAULT = 4'ha;
    // execute_in_place power-on modes
    localparam logic [2:0] EXEC_MODE_OFF = 3'h7;
    // wrap codes and their window masks
    localparam logic [1:0] WRAP_16 = 2'h0;
    localparam logic [1:0] WRAP_32 = 2'h1;
    localparam logic [1:0] WRAP_64 = 2'h2;
    localparam logic [1:0] WRAP_SEQ = 2'h3;
    localparam logic [23:0] MASK_16 = 24'h00000f;
    localparam logic [23:0] MASK_32 = 24'h00001f;
    localparam logic [23:0] MASK_64 = 24'h00003f;
    // register commands
    localparam logic [7:0] CMD_RD_NV = 8'h11;
    localparam logic [7:0] CMD_WR_NV = 8'h12;
    localparam logic [7:0] CMD_RD_VOL = 8'h21;
    localparam logic [7:0] CMD_WR_VOL = 8'h22;
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int NV_WRITE_NS = 1000;
    localparam int NV_WRITE_CYCLES = (NV_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // serial engine phases
    typedef enum logic [2:0] {FCR_BOOT, FCR_IDLE, FCR_DIN, FCR_DOUT, FCR_SKIP} fcr_phase_t;
endpackage

// >>> core/fcr_rd_if.sv
// read-address carrier between the register logic and the wrap address generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface fcr_rd_if;
    logic start;
    logic [23:0] start_addr;
    logic next;
    logic [1:0] wrap;
    logic [23:0] addr;
    modport ctrl (output start, output start_addr, output next, output wrap, input addr);
    modport gen (input start, input start_addr, input next, input wrap, output addr);
endinterface
`default_nettype wire

// >>> dv/fcr_spi_host.sv
// serial host model issuing register commands to the configuration logic
// assumes the core clock paces it; the serial clock rests low outside frames
`timescale 1ns/1ps
`default_nettype none
module fcr_spi_host (
    input wire logic clk,
    output var logic spi_clk,
    output var logic spi_cs_n,
    output var logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n
);
    // serial half period in core cycles, kept above the four-cycle floor
    localparam int HALF = 6;
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // one frame: command byte, nw bytes written, nr bytes read, msb first
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdat, input int nw,
                        input int nr, output logic [15:0] rdat);
        logic [7:0] byt;
        rdat = 16'h0000;
        @(posedge clk);
        spi_cs_n <= 1'b0;
        for (int b = 0; b < 1 + nw + nr; b++) begin
            byt = (b == 0) ? cmd : (b == 1) ? wdat[7:0] : wdat[15:8];
            for (int i = 7; i >= 0; i--) begin
                // while reading, the data-in line toggles instead of holding a stale level
                spi_mosi <= (b > nw) ? ~spi_mosi : byt[i];
                repeat (HALF) @(posedge clk);
                spi_clk <= 1'b1;
                if (b > nw) begin
                    rdat[8 * (b - nw - 1) + i] = spi_miso_oe_n ? 1'bx : spi_miso;
                end
                repeat (HALF) @(posedge clk);
                spi_clk <= 1'b0;
            end
        end
        repeat (HALF) @(posedge clk);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the flash configuration register logic
// assumes the serial host model drives the serial pins; expected values queue for a watcher
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fcr_pkg::*;
;
    localparam int WR_LEN = 200;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic factory_erase = 1'b1;
    logic rd_start = 1'b0;
    logic [23:0] rd_start_addr = 24'h000000;
    logic rd_next = 1'b0;
    wire logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic [23:0] rd_addr;
    logic [3:0] dummy_cycles;
    logic [2:0] execute_in_place_mode;
    logic [1:0] wrap_mode;
    logic execute_in_place, hold_reset_enable, quad_mode, dual_mode, write_in_progress;
    logic [23:0] exp_q[$];
    logic [23:0] got_q[$];
    string nm_q[$];
    int failures = 0;
    int n_tests = 0;
    int wip_run = 0;
    int wip_len = 0;
    logic [15:0] nv_tab[2] = '{16'h3ce3, 16'h0ffb};

    always #2.5 clk = ~clk;

    fcr_core #(.EXEC_FORCED(1'b0), .NV_WRITE_LEN(WR_LEN)) DUT (
        .clk(clk), .reset_n(reset_n), .factory_erase(factory_erase), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .rd_start(rd_start), .rd_start_addr(rd_start_addr),
        .rd_next(rd_next), .rd_addr(rd_addr), .dummy_cycles(dummy_cycles),
        .execute_in_place(execute_in_place), .execute_in_place_mode(execute_in_place_mode),
        .hold_reset_enable(hold_reset_enable), .quad_mode(quad_mode), .dual_mode(dual_mode),
        .wrap_mode(wrap_mode), .write_in_progress(write_in_progress)
    );

    fcr_spi_host host (
        .clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n)
    );

    // length of the last busy stretch, in core cycles
    always @(posedge clk) begin
        if (write_in_progress === 1'b1) begin
            wip_run <= wip_run + 1;
        end else if (wip_run != 0) begin
            wip_len <= wip_run;
            wip_run <= 0;
        end
    end

    // watcher: pairs each observed result with the oldest expectation
    always @(posedge clk) begin
        while (got_q.size() > 0) begin
            n_tests++;
            if (got_q[0] !== exp_q[0]) begin
                failures++;
                $display("Error %s expected %h seen %h", nm_q[0], exp_q[0], got_q[0]);
            end
            void'(got_q.pop_front());
            void'(exp_q.pop_front());
            void'(nm_q.pop_front());
        end
    end

    function automatic void chk(string nm, logic [23:0] e, logic [23:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
        nm_q.push_back(nm);
    endfunction

    // both ends of the code range give the default count
    function automatic logic [3:0] dflt(logic [3:0] dc);
        return (dc == DUMMY_CODE_ZERO || dc == DUMMY_CODE_ONES) ? DUMMY_DEFAULT : dc;
    endfunction

    task automatic end_sim();
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic boot(input logic fe);
        @(posedge clk);
        reset_n <= 1'b0;
        factory_erase <= fe;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        factory_erase <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    // live configuration and both registers after a boot from nonvolatile value v
    task automatic check_cfg(input logic [15:0] v);
        logic [15:0] rd;
        @(posedge clk);
        chk("dummy_cycles", 24'(dflt(v[15:12])), 24'(dummy_cycles));
        chk("execute_in_place_mode", 24'(v[11:9]), 24'(execute_in_place_mode));
        chk("execute_in_place", 24'(v[11:9] != EXEC_MODE_OFF), 24'(execute_in_place));
        chk("hold_reset_enable", 24'(v[4]), 24'(hold_reset_enable));
        chk("quad_mode", 24'(!v[3]), 24'(quad_mode));
        chk("dual_mode", 24'(v[3] && !v[2]), 24'(dual_mode));
        chk("wrap_mode", 24'(WRAP_SEQ), 24'(wrap_mode));
        host.xfer(CMD_RD_NV, 16'h0000, 0, 2, rd);
        chk("nonvolatile_config", 24'(v), 24'(rd));
        host.xfer(CMD_RD_VOL, 16'h0000, 0, 1, rd);
        chk("volatile_config", 24'({v[15:12], v[11:9] == EXEC_MODE_OFF, 3'h3}), 24'(rd));
    endtask

    // read address walk across the end of the window
    task automatic walk(input logic [1:0] wr);
        logic [23:0] m, a;
        m = (wr == WRAP_16) ? MASK_16 : (wr == WRAP_32) ? MASK_32 : MASK_64;
        a = (24'($urandom) & ~m) | (m - 24'h000002);
        @(posedge clk);
        rd_start <= 1'b1;
        rd_start_addr <= a;
        @(posedge clk);
        rd_start <= 1'b0;
        rd_next <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            chk("rd_addr", a, rd_addr);
            // past the last byte of a window the address goes back to the window start
            a = (wr != WRAP_SEQ && (a & m) == m) ? (a & ~m) : a + 24'h000001;
        end
        rd_next <= 1'b0;
    endtask

    initial begin
        logic [15:0] rd;
        logic [15:0] cur;
        logic [7:0] vd;
        logic [3:0] dc;
        int n;
        void'($urandom(1626));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        factory_erase <= 1'b0;
        repeat (10) @(posedge clk);
        cur = NV_DELIVERED;
        check_cfg(cur);
        foreach (nv_tab[j]) begin
            // volatile writes over every wrap code, with code zero and all ones
            // the serial clock runs near 17 MHz, so any dummy count of one or more suffices
            for (int w = 0; w < 4; w++) begin
                dc = (w == 0) ? 4'h0 : (w == 3) ? 4'hf : 4'($urandom_range(1, 14));
                vd = {dc, 1'(w % 2), 1'($urandom), 2'(w)};
                host.xfer(CMD_WR_VOL, {8'h00, vd}, 1, 0, rd);
                @(posedge clk);
                chk("dummy_cycles", 24'(dflt(dc)), 24'(dummy_cycles));
                chk("execute_in_place", 24'(!vd[3]), 24'(execute_in_place));
                chk("wrap_mode", 24'(vd[1:0]), 24'(wrap_mode));
                host.xfer(CMD_RD_VOL, 16'h0000, 0, 1, rd);
                chk("volatile_config", 24'(vd & 8'hfb), 24'(rd));
                walk(vd[1:0]);
            end
            host.xfer(CMD_WR_NV, nv_tab[j], 2, 0, rd);
            chk("quad_mode", 24'(!cur[3]), 24'(quad_mode));
            chk("dual_mode", 24'(cur[3] && !cur[2]), 24'(dual_mode));
            // a second write inside the busy time is dropped; the next boot shows nv_tab[j]
            host.xfer(CMD_WR_NV, ~nv_tab[j], 2, 0, rd);
            for (n = 0; n < 300 && write_in_progress !== 1'b0; n++) begin
                @(posedge clk);
            end
            if (n == 300) begin
                failures++;
                end_sim();
            end
            @(posedge clk);
            chk("write_in_progress", 24'(WR_LEN), 24'(wip_len));
            boot(1'b0);
            cur = nv_tab[j];
            check_cfg(cur);
        end
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule
`default_nettype wire
